// ===== rtl/core_pkg.sv
// Purpose: Shared constants and carriers for the integer execution core
// Assumes: 64-bit data path, one 32-bit instruction word per issue slot
// Notes:   Opcodes are this core's own compact encoding, instruction bit 31 marks 64-bit forms
package core_pkg;

	// Widths
	localparam int XLEN      = 64;
	localparam int NREG      = 32;
	localparam int RIDX      = 5;
	localparam int OPW       = 5;

	// Instruction field positions
	localparam int F_WIDE    = 31;
	localparam int F_OP_HI   = 30;
	localparam int F_OP_LO   = 26;
	localparam int F_RS_LO   = 21;
	localparam int F_RT_LO   = 16;
	localparam int F_RD_LO   = 11;
	localparam int F_IMM_HI  = 15;

	// Operation codes (bits 30:26)
	localparam logic [OPW-1:0] OP_NOP    = 5'h00;
	localparam logic [OPW-1:0] OP_ADD    = 5'h01;
	localparam logic [OPW-1:0] OP_SUB    = 5'h02;
	localparam logic [OPW-1:0] OP_AND    = 5'h03;
	localparam logic [OPW-1:0] OP_OR     = 5'h04;
	localparam logic [OPW-1:0] OP_XOR    = 5'h05;
	localparam logic [OPW-1:0] OP_NOR    = 5'h06;
	localparam logic [OPW-1:0] OP_SLL    = 5'h07;
	localparam logic [OPW-1:0] OP_SRL    = 5'h08;
	localparam logic [OPW-1:0] OP_SRA    = 5'h09;
	localparam logic [OPW-1:0] OP_ADDI   = 5'h0A;
	localparam logic [OPW-1:0] OP_LOAD   = 5'h0B;
	localparam logic [OPW-1:0] OP_STORE  = 5'h0C;
	localparam logic [OPW-1:0] OP_MUL    = 5'h0D;
	localparam logic [OPW-1:0] OP_DIV    = 5'h0E;
	localparam logic [OPW-1:0] OP_CPTOP  = 5'h0F;
	localparam logic [OPW-1:0] OP_CPBOT  = 5'h10;

	// Result-readable latencies of the multiply/divide path, in cycles
	localparam int MUL32_CYC = 6;
	localparam int MUL64_CYC = 7;
	localparam int DIV32_CYC = 42;
	localparam int DIV64_CYC = 74;

	// Reset values
	localparam logic [XLEN-1:0] RST_DATA = 64'h0000000000000000;

	// Decoded instruction
	typedef struct packed {
		logic            valid;
		logic            wide;
		logic [OPW-1:0]  op;
		logic [RIDX-1:0] rs;
		logic [RIDX-1:0] rt;
		logic [RIDX-1:0] rd;
		logic [15:0]     imm;
	} dec_t;

	// Memory-stage contents
	typedef struct packed {
		logic            valid;
		logic            wr;
		logic            load;
		logic            wide;
		logic            req;
		logic            write;
		logic [RIDX-1:0] rd;
		logic [XLEN-1:0] data;
		logic [XLEN-1:0] sdata;
	} mem_t;

	// Write-back contents
	typedef struct packed {
		logic            wr;
		logic [RIDX-1:0] rd;
		logic [XLEN-1:0] data;
	} res_t;

	// Multiply/divide sequencer
	typedef enum logic {MD_IDLE, MD_RUN} md_state_t;

endpackage

// ===== rtl/gpr_file.sv
// Purpose: General register file, two read ports and one write port
// Assumes: Write port is the write-back stage of the pipeline
// Notes:   Register 0 reads as zero; write-through covers same-cycle reads
`timescale 1ns/1ns
`default_nettype none
module gpr_file #(
	parameter int NREG = core_pkg::NREG,
	parameter int XLEN = core_pkg::XLEN
) (
	// Clock
	input  wire logic                    clk,
	// Read ports
	input  wire logic [$clog2(NREG)-1:0] ra_a,
	input  wire logic [$clog2(NREG)-1:0] ra_b,
	output logic      [XLEN-1:0]         rd_a,
	output logic      [XLEN-1:0]         rd_b,
	// Write port
	input  wire logic                    we,
	input  wire logic [$clog2(NREG)-1:0] wa,
	input  wire logic [XLEN-1:0]         wd
);

	logic [XLEN-1:0] regs [NREG];

	// Read with write-through, so write-back needs no extra bypass
	function automatic logic [XLEN-1:0] rdp(input logic [$clog2(NREG)-1:0] a, input logic [XLEN-1:0] v);
		if (a == '0)
			return '0;
		if (we && wa == a)
			return wd;
		return v;
	endfunction

	// Read ports
	always_comb begin
		rd_a = rdp(ra_a, regs[ra_a]);
		rd_b = rdp(ra_b, regs[ra_b]);
	end

	// Single write port
	always_ff @(posedge clk) begin
		if (we)
			regs[wa] <= wd;
	end

endmodule
`default_nettype wire

// ===== rtl/int_muldiv.sv
// Purpose: Integer multiply/divide with results held back by a fixed-latency sequencer
// Assumes: Caller holds off copies and new starts while busy is high
// Notes:   Results commit to the top/bottom registers only at the end of the latency
`timescale 1ns/1ns
`default_nettype none
module int_muldiv #(
	parameter int XLEN = core_pkg::XLEN
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            nrst,
	// Request
	input  wire logic            start,
	input  wire logic            is_div,
	input  wire logic            wide,
	input  wire logic [XLEN-1:0] opa,
	input  wire logic [XLEN-1:0] opb,
	// Status and results
	output logic                 busy,
	output logic      [XLEN-1:0] top_result_register,
	output logic      [XLEN-1:0] bottom_result_register
);

	core_pkg::md_state_t st_q, st_d;
	logic [6:0]          cnt_q, cnt_d;
	logic [XLEN-1:0]     ptop_q, ptop_d, pbot_q, pbot_d;
	logic [XLEN-1:0]     top_q, top_d, bot_q, bot_d;
	logic [2*XLEN-1:0]   prod;
	logic [63:0]         p32;
	logic [31:0]         q32, r32;

	assign busy                   = (st_q == core_pkg::MD_RUN);
	assign top_result_register    = top_q;
	assign bottom_result_register = bot_q;

	// Signed products and quotients; divide by zero gives all ones and the dividend
	always_comb begin
		prod = $signed(opa) * $signed(opb);
		p32  = $signed(opa[31:0]) * $signed(opb[31:0]);
		q32  = (opb[31:0] == '0) ? '1 : 32'($signed(opa[31:0]) / $signed(opb[31:0]));
		r32  = (opb[31:0] == '0) ? opa[31:0] : 32'($signed(opa[31:0]) % $signed(opb[31:0]));
	end

	// Sequencer: latch result at start, expose it after the latency
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		ptop_d = ptop_q;
		pbot_d = pbot_q;
		top_d  = top_q;
		bot_d  = bot_q;
		unique case (st_q)
			core_pkg::MD_IDLE: begin
				if (start) begin
					st_d = core_pkg::MD_RUN;
					if (!is_div)
						cnt_d = wide ? 7'(core_pkg::MUL64_CYC - 2) : 7'(core_pkg::MUL32_CYC - 2);
					else
						cnt_d = wide ? 7'(core_pkg::DIV64_CYC - 2) : 7'(core_pkg::DIV32_CYC - 2);
					if (!is_div && wide) begin
						ptop_d = prod[2*XLEN-1:XLEN];
						pbot_d = prod[XLEN-1:0];
					end else if (!is_div) begin
						ptop_d = {{32{p32[63]}}, p32[63:32]};
						pbot_d = {{32{p32[31]}}, p32[31:0]};
					end else if (wide) begin
						ptop_d = (opb == '0) ? opa : XLEN'($signed(opa) % $signed(opb));
						pbot_d = (opb == '0) ? '1 : XLEN'($signed(opa) / $signed(opb));
					end else begin
						ptop_d = {{32{r32[31]}}, r32};
						pbot_d = {{32{q32[31]}}, q32};
					end
				end
			end
			core_pkg::MD_RUN: begin
				if (cnt_q == '0) begin
					top_d = ptop_q;
					bot_d = pbot_q;
					st_d  = core_pkg::MD_IDLE;
				end else begin
					cnt_d = cnt_q - 7'h01;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q   <= core_pkg::MD_IDLE;
			cnt_q  <= 7'h00;
			ptop_q <= core_pkg::RST_DATA;
			pbot_q <= core_pkg::RST_DATA;
			top_q  <= core_pkg::RST_DATA;
			bot_q  <= core_pkg::RST_DATA;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			ptop_q <= ptop_d;
			pbot_q <= pbot_d;
			top_q  <= top_d;
			bot_q  <= bot_d;
		end
	end

endmodule
`default_nettype wire

// ===== rtl/integer_execution_core.sv
// Purpose: Five-stage integer pipeline with bypassed register file and ALU
// Assumes: Data cache answers within the memory stage; issue is synchronous
// Notes:   One spare issue slot lets the registered ready lag the stall by a cycle
`timescale 1ns/1ns
`default_nettype none
module integer_execution_core (
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	// Instruction issue
	input  wire logic        ISSUE_VALID,
	input  wire logic [31:0] ISSUE_INSTR,
	output logic             ISSUE_READY,
	// Operating mode
	input  wire logic        MODE_64,
	// Data cache port
	output logic             DC_REQ,
	output logic             DC_WRITE,
	output logic      [63:0] DC_VADDR,
	output logic      [63:0] DC_WDATA,
	input  wire logic [63:0] DC_RDATA,
	// Retirement and exceptions
	output logic             WB_VALID,
	output logic      [4:0]  WB_REG,
	output logic      [63:0] WB_DATA,
	output logic             EXC_RESERVED
);

	localparam int XLEN = core_pkg::XLEN;

	core_pkg::dec_t  sp_q, sp_d, id_q, id_d, ex_q, ex_d, in_dec;
	core_pkg::mem_t  mem_q, mem_d;
	core_pkg::res_t  wb_q, wb_d;
	logic [XLEN-1:0] ea_q, ea_d, eb_q, eb_d;
	logic            rdy_q, rdy_d, exc_q, exc_d;
	logic [XLEN-1:0] rf_a, rf_b, opa, opb, res;
	logic [XLEN-1:0] md_top, md_bot;
	logic            md_busy, md_start, accept, stall, load_use, md_wait, illegal;

	// Outputs straight from pipeline registers
	assign ISSUE_READY  = rdy_q;
	assign DC_REQ       = mem_q.req;
	assign DC_WRITE     = mem_q.write;
	assign DC_VADDR     = mem_q.data;
	assign DC_WDATA     = mem_q.sdata;
	assign WB_VALID     = wb_q.wr;
	assign WB_REG       = wb_q.rd;
	assign WB_DATA      = wb_q.data;
	assign EXC_RESERVED = exc_q;

	// Field split of an issued word
	function automatic core_pkg::dec_t decode(input logic [31:0] w, input logic v);
		core_pkg::dec_t d;
		d.valid = v;
		d.wide  = w[core_pkg::F_WIDE];
		d.op    = w[core_pkg::F_OP_HI:core_pkg::F_OP_LO];
		d.rs    = w[core_pkg::F_RS_LO+4:core_pkg::F_RS_LO];
		d.rt    = w[core_pkg::F_RT_LO+4:core_pkg::F_RT_LO];
		d.rd    = w[core_pkg::F_RD_LO+4:core_pkg::F_RD_LO];
		d.imm   = w[core_pkg::F_IMM_HI:0];
		return d;
	endfunction

	// Narrow results are sign-extended from bit 31
	function automatic logic [XLEN-1:0] fit(input logic [XLEN-1:0] v, input logic wide);
		return wide ? v : {{32{v[31]}}, v[31:0]};
	endfunction

	// Shared adder for arithmetic and addresses
	function automatic logic [XLEN-1:0] adder(input logic [XLEN-1:0] a, input logic [XLEN-1:0] b,
		input logic sub, input logic wide);
		return fit(sub ? a - b : a + b, wide);
	endfunction

	// Forwarding: memory stage is younger, so it wins over write-back
	function automatic logic [XLEN-1:0] fwd(input logic [4:0] r, input logic [XLEN-1:0] base,
		input core_pkg::mem_t m, input core_pkg::res_t w);
		if (r == '0)
			return '0;
		if (m.valid && m.wr && !m.load && m.rd == r)
			return m.data;
		if (w.wr && w.rd == r)
			return w.data;
		return base;
	endfunction

	// Ops that read or write the multiply/divide unit
	function automatic logic uses_md(input core_pkg::dec_t d);
		return d.valid && (d.op == core_pkg::OP_MUL || d.op == core_pkg::OP_DIV ||
			d.op == core_pkg::OP_CPTOP || d.op == core_pkg::OP_CPBOT);
	endfunction

	// Ops that write a general register
	function automatic logic writes_gpr(input logic [4:0] op);
		return (op >= core_pkg::OP_ADD && op <= core_pkg::OP_LOAD) ||
			op == core_pkg::OP_CPTOP || op == core_pkg::OP_CPBOT;
	endfunction

	gpr_file #(
		.NREG (core_pkg::NREG),
		.XLEN (XLEN)
	) u_gpr (
		.clk  (CLK_SYS),
		.ra_a (id_q.rs),
		.ra_b (id_q.rt),
		.rd_a (rf_a),
		.rd_b (rf_b),
		.we   (wb_q.wr),
		.wa   (wb_q.rd),
		.wd   (wb_q.data)
	);

	int_muldiv #(
		.XLEN (XLEN)
	) u_md (
		.clk                    (CLK_SYS),
		.nrst                   (NRST),
		.start                  (md_start),
		.is_div                 (ex_q.op == core_pkg::OP_DIV),
		.wide                   (ex_q.wide),
		.opa                    (opa),
		.opb                    (opb),
		.busy                   (md_busy),
		.top_result_register    (md_top),
		.bottom_result_register (md_bot)
	);

	// Hazard detection in decode/read
	always_comb begin
		load_use = ex_q.valid && ex_q.op == core_pkg::OP_LOAD && ex_q.rd != '0 &&
			(ex_q.rd == id_q.rs || ex_q.rd == id_q.rt);
		// multiply/divide interlock
		// A copy in execute starts nothing, so a copy right behind it flows on
		md_wait  = uses_md(id_q) && (md_busy || md_start);
		stall    = id_q.valid && (load_use || md_wait);
		illegal  = id_q.valid && id_q.wide && !MODE_64;
	end

	// Execute stage: operand bypass and single-cycle ALU
	always_comb begin
		opa = fwd(ex_q.rs, ea_q, mem_q, wb_q);
		opb = fwd(ex_q.rt, eb_q, mem_q, wb_q);
		unique case (ex_q.op)
			core_pkg::OP_ADD:   res = adder(opa, opb, 1'b0, ex_q.wide);
			core_pkg::OP_SUB:   res = adder(opa, opb, 1'b1, ex_q.wide);
			core_pkg::OP_ADDI:  res = adder(opa, {{48{ex_q.imm[15]}}, ex_q.imm}, 1'b0, ex_q.wide);
			core_pkg::OP_LOAD,
			core_pkg::OP_STORE: res = adder(opa, {{48{ex_q.imm[15]}}, ex_q.imm}, 1'b0, 1'b1);
			core_pkg::OP_AND:   res = opa & opb;
			core_pkg::OP_OR:    res = opa | opb;
			core_pkg::OP_XOR:   res = opa ^ opb;
			core_pkg::OP_NOR:   res = ~(opa | opb);
			core_pkg::OP_SLL:   res = fit(opa << (ex_q.wide ? ex_q.imm[5:0] : {1'b0, ex_q.imm[4:0]}), ex_q.wide);
			core_pkg::OP_SRL:   res = ex_q.wide ? opa >> ex_q.imm[5:0] :
				fit({32'h00000000, opa[31:0] >> ex_q.imm[4:0]}, 1'b0);
			core_pkg::OP_SRA:   res = ex_q.wide ? XLEN'($signed(opa) >>> ex_q.imm[5:0]) :
				fit({32'h00000000, 32'($signed(opa[31:0]) >>> ex_q.imm[4:0])}, 1'b0);
			core_pkg::OP_CPTOP: res = md_top;
			core_pkg::OP_CPBOT: res = md_bot;
			default:            res = '0;
		endcase
		md_start = ex_q.valid && (ex_q.op == core_pkg::OP_MUL || ex_q.op == core_pkg::OP_DIV);
	end

	// Pipeline advance
	always_comb begin
		in_dec = decode(ISSUE_INSTR, 1'b1);
		accept = ISSUE_VALID && rdy_q;
		sp_d   = sp_q;
		id_d   = id_q;
		ex_d   = ex_q;
		ea_d   = rf_a;
		eb_d   = rf_b;
		if (!stall) begin
			if (sp_q.valid) begin
				id_d       = sp_q;
				sp_d       = in_dec;
				sp_d.valid = accept;
			end else begin
				id_d       = in_dec;
				id_d.valid = accept;
				sp_d.valid = 1'b0;
			end
			ex_d       = id_q;
			ex_d.valid = id_q.valid && !illegal;
		end else begin
			if (accept)
				sp_d = in_dec;
			// Bubble into execute while decode holds
			ex_d.valid = 1'b0;
		end
		// Ready lags one cycle, so it must leave room for one more word
		rdy_d = !sp_d.valid;
		exc_d = illegal && !stall;

		// only loads and stores reach memory
		mem_d.valid = ex_q.valid;
		mem_d.wr    = ex_q.valid && writes_gpr(ex_q.op);
		mem_d.load  = ex_q.op == core_pkg::OP_LOAD;
		mem_d.wide  = ex_q.wide;
		mem_d.req   = ex_q.valid && (ex_q.op == core_pkg::OP_LOAD || ex_q.op == core_pkg::OP_STORE);
		mem_d.write = ex_q.valid && ex_q.op == core_pkg::OP_STORE;
		mem_d.rd    = ex_q.rd;
		mem_d.data  = res;
		mem_d.sdata = fit(opb, ex_q.wide);

		// Write-back takes load data as the cache answers in the memory stage
		wb_d.wr   = mem_q.valid && mem_q.wr && mem_q.rd != '0;
		wb_d.rd   = mem_q.rd;
		wb_d.data = mem_q.load ? fit(DC_RDATA, mem_q.wide) : mem_q.data;
	end

	// Pipeline registers
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			sp_q  <= '0;
			id_q  <= '0;
			ex_q  <= '0;
			ea_q  <= core_pkg::RST_DATA;
			eb_q  <= core_pkg::RST_DATA;
			mem_q <= '0;
			wb_q  <= '0;
			rdy_q <= 1'b0;
			exc_q <= 1'b0;
		end else begin
			sp_q  <= sp_d;
			id_q  <= id_d;
			ex_q  <= ex_d;
			ea_q  <= ea_d;
			eb_q  <= eb_d;
			mem_q <= mem_d;
			wb_q  <= wb_d;
			rdy_q <= rdy_d;
			exc_q <= exc_d;
		end
	end

endmodule
`default_nettype wire

// ===== sim/integer_execution_core_props.sv
// Purpose: Port-level assertions for the integer execution core
// Assumes: MODE_64 changes only while the pipeline is empty
// Notes:   Flow checks only fire when ready stays high, so stalls never confuse slots
`timescale 1ns/1ns
`default_nettype none
module integer_execution_core_props (
	// Clock and reset
	input wire logic        CLK_SYS,
	input wire logic        NRST,
	// Issue side
	input wire logic        ISSUE_VALID,
	input wire logic [31:0] ISSUE_INSTR,
	input wire logic        ISSUE_READY,
	input wire logic        MODE_64,
	// Results
	input wire logic        DC_REQ,
	input wire logic        DC_WRITE,
	input wire logic        WB_VALID,
	input wire logic [4:0]  WB_REG,
	input wire logic        EXC_RESERVED
);
	logic [4:0] op;
	logic [4:0] dest;
	logic       take;
	logic       legal;
	logic       alu_op;
	logic       mem_op;
	logic       quiet_op;
	logic       is_store;

	// Decode of the word offered this cycle
	assign op = ISSUE_INSTR[30:26];
	assign dest = ISSUE_INSTR[15:11];
	assign take = ISSUE_VALID && ISSUE_READY;
	assign legal = MODE_64 || !ISSUE_INSTR[31];
	assign alu_op = (op inside {[core_pkg::OP_ADD:core_pkg::OP_ADDI], core_pkg::OP_CPTOP, core_pkg::OP_CPBOT})
		&& dest != 5'h00;
	assign mem_op = op == core_pkg::OP_LOAD || op == core_pkg::OP_STORE;
	assign quiet_op = op inside {core_pkg::OP_NOP, core_pkg::OP_MUL, core_pkg::OP_DIV};
	assign is_store = op == core_pkg::OP_STORE;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);

	// Word taken, the next one taken behind it, so decode never held it
	sequence clean_flow(cond);
		take && cond ##1 take ##1 ISSUE_READY [*2];
	endsequence

	reset_quiet_a: assert property (disable iff (1'b0)
		!NRST |=> !ISSUE_READY && !DC_REQ && !WB_VALID && !EXC_RESERVED) else $error("outputs active in reset");
	ready_release_a: assert property ($rose(NRST) |-> !ISSUE_READY ##1 ISSUE_READY)
		else $error("ready not raised after reset");
	alu_wb_a: assert property (clean_flow(legal && alu_op) |=> WB_VALID && WB_REG == $past(dest, 4))
		else $error("alu result not written in slot");
	mem_flow_a: assert property (clean_flow(legal && mem_op) |-> DC_REQ && DC_WRITE == $past(is_store, 3))
		else $error("memory access missing");
	no_access_a: assert property (clean_flow(legal && !mem_op) |-> !DC_REQ)
		else $error("memory touched by non-memory op");
	quiet_a: assert property (clean_flow(legal && quiet_op) |=> !WB_VALID)
		else $error("general register written by quiet op");
	exc_raise_a: assert property (clean_flow(!legal) |-> $past(EXC_RESERVED) ##1 !WB_VALID)
		else $error("wide form not refused");
	exc_mode_a: assert property (EXC_RESERVED |-> !$past(MODE_64, 3))
		else $error("exception in 64-bit mode");
	wb_nonzero_a: assert property (WB_VALID |-> WB_REG != 5'h00)
		else $error("write to register zero");
endmodule
`default_nettype wire

// ===== sim/integer_execution_core_test.sv
// Purpose: Self-checking bench for the integer execution core
// Assumes: Mode changes only after the pipeline drains
// Notes:   Reference model runs at issue time; results are checked in order
`timescale 1ns/1ns
`default_nettype none
module integer_execution_core_test;
	logic         CLK_SYS = 1'b0;
	logic         NRST = 1'b0;
	logic         ISSUE_VALID = 1'b0;
	logic [31:0]  ISSUE_INSTR = 32'h00000000;
	logic         MODE_64 = 1'b1;
	logic [63:0]  DC_RDATA = 64'h0000000000000000;
	logic         ISSUE_READY;
	logic         DC_REQ;
	logic         DC_WRITE;
	logic         WB_VALID;
	logic         EXC_RESERVED;
	logic [63:0]  DC_VADDR;
	logic [63:0]  DC_WDATA;
	logic [63:0]  WB_DATA;
	logic [4:0]   WB_REG;
	int           errors = 0;
	int           check_count = 0;
	int           stalls = 0;
	int           exc_seen = 0;
	int           exc_exp = 0;
	logic [63:0]  rf [32] = '{default: 64'h0};
	logic [63:0]  top_m = core_pkg::RST_DATA;
	logic [63:0]  bot_m = core_pkg::RST_DATA;
	logic [68:0]  wb_q [$];
	logic [128:0] dc_q [$];
	logic [68:0]  we;
	logic [128:0] de;

	always #25 CLK_SYS = ~CLK_SYS;

	integer_execution_core dut_u (
		.CLK_SYS      (CLK_SYS),
		.NRST         (NRST),
		.ISSUE_VALID  (ISSUE_VALID),
		.ISSUE_INSTR  (ISSUE_INSTR),
		.ISSUE_READY  (ISSUE_READY),
		.MODE_64      (MODE_64),
		.DC_REQ       (DC_REQ),
		.DC_WRITE     (DC_WRITE),
		.DC_VADDR     (DC_VADDR),
		.DC_WDATA     (DC_WDATA),
		.DC_RDATA     (DC_RDATA),
		.WB_VALID     (WB_VALID),
		.WB_REG       (WB_REG),
		.WB_DATA      (WB_DATA),
		.EXC_RESERVED (EXC_RESERVED)
	);

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	function automatic logic [63:0] sx(input logic [31:0] v);
		return {{32{v[31]}}, v};
	endfunction

	// Biased toward low registers so neighbours depend on each other
	function automatic logic [4:0] reg5();
		return 5'($urandom_range(0, 31)) & ($urandom_range(0, 1) ? 5'h1F : 5'h03);
	endfunction

	// Shift amount sits in both candidate fields, narrow forms only where defined
	function automatic logic [31:0] rnd();
		logic [4:0] op;
		logic [4:0] sh;
		logic       wide;
		op = 5'($urandom_range(0, 16));
		sh = 5'($urandom);
		wide = op inside {core_pkg::OP_ADD, core_pkg::OP_SUB, core_pkg::OP_ADDI, core_pkg::OP_MUL, core_pkg::OP_DIV}
			? 1'($urandom) : 1'b1;
		return {wide && op != core_pkg::OP_NOP, op, reg5(), reg5(), reg5(), sh, 1'b0, sh};
	endfunction

	// Model the word in program order, then offer it until taken
	task automatic issue(input logic [31:0] w);
		logic [63:0]         a;
		logic [63:0]         b;
		logic [63:0]         r;
		logic [63:0]         ea;
		logic signed [63:0]  sa;
		logic signed [63:0]  sb;
		logic signed [127:0] p;
		logic                wr;
		a = rf[w[25:21]];
		b = rf[w[20:16]];
		if (!w[31]) begin
			a = sx(a[31:0]);
			b = sx(b[31:0]);
		end
		sa = a;
		sb = b;
		ea = a + {{48{w[15]}}, w[15:0]};
		r = 64'h0;
		wr = 1'b1;
		if (w[31] && !MODE_64) begin
			exc_exp++;
			wr = 1'b0;
		end else begin
			case (w[30:26])
				core_pkg::OP_ADD:   r = a + b;
				core_pkg::OP_SUB:   r = a - b;
				core_pkg::OP_AND:   r = a & b;
				core_pkg::OP_OR:    r = a | b;
				core_pkg::OP_XOR:   r = a ^ b;
				core_pkg::OP_NOR:   r = ~(a | b);
				core_pkg::OP_SLL:   r = a << w[4:0];
				core_pkg::OP_SRL:   r = a >> w[4:0];
				core_pkg::OP_SRA:   r = sa >>> w[4:0];
				core_pkg::OP_ADDI:  r = ea;
				core_pkg::OP_CPTOP: r = top_m;
				core_pkg::OP_CPBOT: r = bot_m;
				core_pkg::OP_LOAD: begin
					r = {$urandom, $urandom};
					dc_q.push_back({1'b0, ea, r});
				end
				core_pkg::OP_STORE: begin
					dc_q.push_back({1'b1, ea, b});
					wr = 1'b0;
				end
				core_pkg::OP_MUL: begin
					p = sa * sb;
					top_m = w[31] ? p[127:64] : sx(p[63:32]);
					bot_m = w[31] ? p[63:0] : sx(p[31:0]);
					wr = 1'b0;
				end
				core_pkg::OP_DIV: begin
					top_m = a;
					bot_m = '1;
					if (b != 64'h0) begin
						top_m = sa % sb;
						bot_m = sa / sb;
					end
					if (!w[31]) begin
						top_m = sx(top_m[31:0]);
						bot_m = sx(bot_m[31:0]);
					end
					wr = 1'b0;
				end
				default: wr = 1'b0;
			endcase
		end
		if (!w[31]) begin
			r = sx(r[31:0]);
		end
		if (wr && w[15:11] != 5'h00) begin
			rf[w[15:11]] = r;
			wb_q.push_back({w[15:11], r});
		end
		@(negedge CLK_SYS);
		ISSUE_VALID = 1'b1;
		ISSUE_INSTR = w;
		while (!ISSUE_READY) begin
			stalls++;
			@(negedge CLK_SYS);
		end
	endtask

	task automatic drain();
		@(negedge CLK_SYS);
		ISSUE_VALID = 1'b0;
		for (int k = 0; k < 300 && wb_q.size() + dc_q.size() > 0; k++) begin
			@(negedge CLK_SYS);
		end
		repeat (8) @(negedge CLK_SYS);
		chk("pending results", 64'h0, 64'(wb_q.size() + dc_q.size()));
		chk("exceptions", 64'(exc_exp), 64'(exc_seen));
	endtask

	// Result monitor and cache responder; idle read data changes every cycle
	always @(negedge CLK_SYS) begin
		if (NRST && WB_VALID) begin
			we = wb_q.size() ? wb_q.pop_front() : '1;
			chk("wb reg", 64'(we[68:64]), 64'(WB_REG));
			chk("wb data", we[63:0], WB_DATA);
		end
		if (NRST && DC_REQ) begin
			de = dc_q.size() ? dc_q.pop_front() : '1;
			chk("dc write", 64'(de[128]), 64'(DC_WRITE));
			chk("dc addr", de[127:64], DC_VADDR);
			if (DC_WRITE) begin
				chk("dc data", de[63:0], DC_WDATA);
			end
		end
		DC_RDATA <= (NRST && DC_REQ && !DC_WRITE) ? de[63:0] : {$urandom, $urandom};
		if (NRST && EXC_RESERVED) begin
			exc_seen++;
		end
	end

	initial begin
		#(50 * 20000);
		errors++;
		wrap_up();
	end

	initial begin
		logic [31:0] w;
		int          lat;
		int          s;
		void'($urandom(59));
		repeat (12) @(negedge CLK_SYS);
		chk("reset outputs", 64'h0, 64'({ISSUE_READY, DC_REQ, WB_VALID, EXC_RESERVED}));
		NRST = 1'b1;
		// Fill registers 1 to 31 by back-to-back loads
		for (int i = 1; i < 32; i++) begin
			issue({1'b1, core_pkg::OP_LOAD, 10'h000, 5'(i), 11'h000});
		end
		repeat (400) issue(rnd());
		drain();
		MODE_64 = 1'b0;
		repeat (150) issue(rnd());
		drain();
		MODE_64 = 1'b1;
		// Copy right behind, then copy after the full latency with no stall
		for (int i = 0; i < 4; i++) begin
			w = {i[0], (i > 1) ? core_pkg::OP_DIV : core_pkg::OP_MUL, 5'h01, 5'h02, 16'h0000};
			lat = (i > 1) ? (i[0] ? core_pkg::DIV64_CYC : core_pkg::DIV32_CYC)
				: (i[0] ? core_pkg::MUL64_CYC : core_pkg::MUL32_CYC);
			issue(w);
			issue({1'b1, core_pkg::OP_CPTOP, 10'h000, 5'h03, 11'h000});
			issue(w);
			// Baseline after the hazard above has fully drained
			repeat (lat) issue(32'h00000000);
			s = stalls;
			issue({1'b1, core_pkg::OP_CPTOP, 10'h000, 5'h03, 11'h000});
			issue({1'b1, core_pkg::OP_CPBOT, 10'h000, 5'h04, 11'h000});
			issue(32'h00000000);
			chk("stalls after latency", 64'(s), 64'(stalls));
		end
		drain();
		wrap_up();
	end
endmodule

bind integer_execution_core integer_execution_core_props chk_u (
	.CLK_SYS      (CLK_SYS),
	.NRST         (NRST),
	.ISSUE_VALID  (ISSUE_VALID),
	.ISSUE_INSTR  (ISSUE_INSTR),
	.ISSUE_READY  (ISSUE_READY),
	.MODE_64      (MODE_64),
	.DC_REQ       (DC_REQ),
	.DC_WRITE     (DC_WRITE),
	.WB_VALID     (WB_VALID),
	.WB_REG       (WB_REG),
	.EXC_RESERVED (EXC_RESERVED)
);
`default_nettype wire
